// ---- pvc_pkg.sv ----
// Purpose: Constants for the port V pin configuration block.
// Assumes: Byte-wide register port, one 125 MHz bus clock.
// Notes: Offsets are local indices of this block's register window.
//
// Behaviour
// - Data and input reads may lag a direction change by up to two clocks; the code lags three, as PIN_OE is registered ahead of the synchroniser.
// - Reserved locations read zero; writes to them do nothing.
// - Each pull enable bit turns on a pull device only on an input pin.
// - Pull enable has no influence while the pin is an output.
// - After reset all pull enable bits are clear.
// - Polarity 1 selects pull-down, 0 selects pull-up, for enabled input pulls.
// - Polarity bits also choose the active interrupt edge per pin.
// - Slew bit 1 enables slew control and disables the input buffer.
// - In deep stop, slew control is forced off regardless of the register.
// - With motor controller off, routed enabled bus/shutdown inputs keep buffers on.
// - Route bit 2: channel two on pin four when 0, alternate pin two when 1.
// - Route bit 3: channel three on pin six when 0, alternate pin three when 1.
// - Every pin serves as general purpose I/O or peripheral input/output.
// - All configuration registers accept writes at any time.
// - Data reads return pin state when direction is 0, register when 1.
package pvc_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_INPUT = 4'h1;
  localparam logic [3:0] ADDR_DIR = 4'h2;
  localparam logic [3:0] ADDR_RSVD_LO = 4'h3;
  localparam logic [3:0] ADDR_RSVD_HI = 4'h7;
  localparam logic [3:0] ADDR_PULL_EN = 4'h8;
  localparam logic [3:0] ADDR_PULL_POL = 4'h9;
  localparam logic [3:0] ADDR_SLEW = 4'hA;
  localparam logic [3:0] ADDR_ROUTE = 4'hB;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] IBUF_RESET_BYTE = 8'hFF;
  localparam logic [7:0] ROUTE_MASK = 8'h0C;
  localparam int ROUTE_CH2_BIT = 2;
  localparam int ROUTE_CH3_BIT = 3;
  localparam int PIN_CH2 = 4;
  localparam int PIN_CH3 = 6;
  localparam int SYNC_STAGES = 2;
  // ********************
  // Timing
  // ********************
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLEW_SETTLE_NS = 300;
  localparam int SLEW_SETTLE_CYC = SLEW_SETTLE_NS / CLK_PERIOD_NS;
endpackage

// ---- pvc_top.sv ----
// Purpose: Port V pull, slew, routing and readback configuration.
// Assumes: Pin inputs and peripheral controls are synchronous to CLK.
// Notes: Data/direction registers drive the pins when no peripheral owns them, and serve readback.
//        Every output is a flop, so each pin control lags its cause by one clock.
//        The 300 ns slew settling time is left to software; no counter times it.
//        Peripheral ownership, stop mode and buffer keeping arrive as plain inputs.
//        Reserved and unmapped locations read as zero and ignore writes.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pvc_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] PIN_IN,
  input wire logic [7:0] PERIPH_OE,
  input wire logic [7:0] PERIPH_OUT,
  input wire logic [7:0] PERIPH_EN,
  input wire logic [7:0] KEEP_BUF,
  input wire logic MOTOR_EN,
  input wire logic STOP_MODE,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic [7:0] PULL_UP_EN,
  output logic [7:0] PULL_DN_EN,
  output logic [7:0] SLEW_EN,
  output logic [7:0] IBUF_EN,
  output logic [7:0] EDGE_RISE,
  output logic ROUTE_CH2_ALT,
  output logic ROUTE_CH3_ALT
);
  // ********************
  // Registers
  // ********************
  // Software-visible configuration.
  logic [7:0] data_r;
  logic [7:0] dir_r;
  logic [7:0] pull_en_r;
  logic [7:0] pull_pol_r;
  logic [7:0] slew_r;
  logic [7:0] route_r;

  // Input synchroniser stages and the registered read data.
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] rdata_r;

  // Output flops; each top-level output except RDATA, which comes from rdata_r, comes straight from one of these.
  logic [7:0] pin_out_r;
  logic [7:0] pin_oe_r;
  logic [7:0] pu_r;
  logic [7:0] pd_r;
  logic [7:0] slew_en_r;
  logic [7:0] ibuf_r;
  logic [7:0] edge_r;
  logic rt2_r;
  logic rt3_r;

  // ********************
  // Address decode
  // ********************

  // Address decode; reserved and unmapped locations select nothing.
  wire sel_data = (ADDR == pvc_pkg::ADDR_DATA);
  wire sel_input = (ADDR == pvc_pkg::ADDR_INPUT);
  wire sel_dir = (ADDR == pvc_pkg::ADDR_DIR);
  wire sel_pe = (ADDR == pvc_pkg::ADDR_PULL_EN);
  wire sel_pp = (ADDR == pvc_pkg::ADDR_PULL_POL);
  wire sel_slew = (ADDR == pvc_pkg::ADDR_SLEW);
  wire sel_route = (ADDR == pvc_pkg::ADDR_ROUTE);

  // ********************
  // Pin control
  // ********************
  // Effective pin state: a peripheral owns the direction when enabled.
  // The pull gate uses the same direction that drives the pin, so a pull
  // and the output driver can never be on together for one clock.
  wire [7:0] oe_nxt = (PERIPH_EN & PERIPH_OE) | (~PERIPH_EN & dir_r);
  wire [7:0] out_nxt = (PERIPH_EN & PERIPH_OUT) | (~PERIPH_EN & data_r);
  wire [7:0] pull_act = pull_en_r & ~oe_nxt;
  wire [7:0] pu_nxt = pull_act & ~pull_pol_r;
  wire [7:0] pd_nxt = pull_act & pull_pol_r;
  // Stop mode forces slew off, which also releases the input buffers.
  wire [7:0] slew_nxt = STOP_MODE ? 8'h00 : slew_r;
  wire [7:0] keep = MOTOR_EN ? 8'h00 : KEEP_BUF;
  wire [7:0] ibuf_nxt = ~slew_nxt | keep;

  // ********************
  // Read path
  // ********************
  // Read mux; the data view picks pins or latch per direction bit.
  // Pin levels are only seen through the synchroniser, hence the two-clock lag.
  wire [7:0] data_view = (dir_r & data_r) | (~dir_r & sync2_r);
  wire [7:0] rd_nxt = sel_data ? data_view :
                      sel_input ? sync2_r :
                      sel_dir ? dir_r :
                      sel_pe ? pull_en_r :
                      sel_pp ? pull_pol_r :
                      sel_slew ? slew_r :
                      sel_route ? route_r : pvc_pkg::RESET_BYTE;

  // ********************
  // Register file
  // ********************
  // Software writes; accepted at any time regardless of pin usage.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      data_r <= pvc_pkg::RESET_BYTE;
      dir_r <= pvc_pkg::RESET_BYTE;
      pull_en_r <= pvc_pkg::RESET_BYTE;
      pull_pol_r <= pvc_pkg::RESET_BYTE;
      slew_r <= pvc_pkg::RESET_BYTE;
      route_r <= pvc_pkg::RESET_BYTE;
    end else if (WR) begin
      if (sel_data) data_r <= WDATA;
      if (sel_dir) dir_r <= WDATA;
      if (sel_pe) pull_en_r <= WDATA;
      if (sel_pp) pull_pol_r <= WDATA;
      if (sel_slew) slew_r <= WDATA;
      if (sel_route) route_r <= WDATA & pvc_pkg::ROUTE_MASK;
    end
  end

  // Two-stage input synchroniser; with the PIN_OE flop ahead of it, this makes the three-clock readback lag after a turn-around.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_r <= pvc_pkg::RESET_BYTE;
      sync2_r <= pvc_pkg::RESET_BYTE;
    end else begin
      sync1_r <= PIN_IN;
      sync2_r <= sync1_r;
    end
  end

  // ********************
  // Output flops
  // ********************
  // Registered outputs and read data; the input buffers are on out of reset
  // because slew control starts off.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_r <= pvc_pkg::RESET_BYTE;
      pin_out_r <= pvc_pkg::RESET_BYTE;
      pin_oe_r <= pvc_pkg::RESET_BYTE;
      pu_r <= pvc_pkg::RESET_BYTE;
      pd_r <= pvc_pkg::RESET_BYTE;
      slew_en_r <= pvc_pkg::RESET_BYTE;
      ibuf_r <= pvc_pkg::IBUF_RESET_BYTE;
      edge_r <= pvc_pkg::RESET_BYTE;
      rt2_r <= 1'b0;
      rt3_r <= 1'b0;
    end else begin
      rdata_r <= RD ? rd_nxt : pvc_pkg::RESET_BYTE;
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      slew_en_r <= slew_nxt;
      ibuf_r <= ibuf_nxt;
      edge_r <= pull_pol_r;
      rt2_r <= route_r[pvc_pkg::ROUTE_CH2_BIT];
      rt3_r <= route_r[pvc_pkg::ROUTE_CH3_BIT];
    end
  end

  assign RDATA = rdata_r;
  assign PIN_OUT = pin_out_r;
  assign PIN_OE = pin_oe_r;
  assign PULL_UP_EN = pu_r;
  assign PULL_DN_EN = pd_r;
  assign SLEW_EN = slew_en_r;
  assign IBUF_EN = ibuf_r;
  assign EDGE_RISE = edge_r;
  assign ROUTE_CH2_ALT = rt2_r;
  assign ROUTE_CH3_ALT = rt3_r;

  // ********************
  // Assertions
  // ********************
  // Reserved locations must read as zero.
  rsvd_read_zero_a: assert property (@(posedge CLK) disable iff (RESET)
    RD && ADDR >= pvc_pkg::ADDR_RSVD_LO && ADDR <= pvc_pkg::ADDR_RSVD_HI |=> RDATA == 8'h00)
    else $error("reserved read not zero");

  // A write to a reserved location must leave the pull enable, slew, route and direction registers alone.
  rsvd_write_a: assert property (@(posedge CLK) disable iff (RESET)
    WR && ADDR >= pvc_pkg::ADDR_RSVD_LO && ADDR <= pvc_pkg::ADDR_RSVD_HI |=>
    $stable(pull_en_r) && $stable(slew_r) && $stable(route_r) && $stable(dir_r))
    else $error("reserved write changed state");

  // No pull device may be on while the pin drives.
  pull_out_off_a: assert property (@(posedge CLK) disable iff (RESET)
    ((PULL_UP_EN | PULL_DN_EN) & PIN_OE) == 8'h00)
    else $error("pull active on output");

  // Pull-down follows a set polarity bit on enabled inputs.
  pull_pol_sel_a: assert property (@(posedge CLK) disable iff (RESET)
    ##1 (PULL_DN_EN == ($past(pull_en_r) & ~$past(oe_nxt) & $past(pull_pol_r))))
    else $error("pull polarity wrong");

  // Pull-up follows a clear polarity bit on enabled inputs.
  pull_up_sel_a: assert property (@(posedge CLK) disable iff (RESET)
    1'b1 |=> PULL_UP_EN == ($past(pull_en_r) & ~$past(oe_nxt) & ~$past(pull_pol_r)))
    else $error("pull-up select wrong");

  // While reset is applied, no pull device is on.
  pull_reset_a: assert property (@(posedge CLK)
    RESET |-> (PULL_UP_EN | PULL_DN_EN) == 8'h00)
    else $error("pull active in reset");

  // Stop mode overrides the slew register.
  stop_slew_off_a: assert property (@(posedge CLK) disable iff (RESET)
    STOP_MODE |=> SLEW_EN == 8'h00 && IBUF_EN == 8'hFF)
    else $error("slew not forced off in stop");

  // Outside stop, slew control follows the register.
  slew_follow_a: assert property (@(posedge CLK) disable iff (RESET)
    !STOP_MODE |=> SLEW_EN == $past(slew_r))
    else $error("slew does not follow register");

  // With the motor controller on nothing keeps a buffer, so it is the inverse of slew.
  slew_buf_a: assert property (@(posedge CLK) disable iff (RESET)
    !STOP_MODE && MOTOR_EN |=> IBUF_EN == ~SLEW_EN)
    else $error("input buffer not opposite of slew");

  // Routing bit 2 reaches its output two clocks after the write.
  route_ch2_a: assert property (@(posedge CLK) disable iff (RESET)
    WR && sel_route |=> ##1 ROUTE_CH2_ALT == $past(WDATA[2], 2))
    else $error("channel two route wrong");

  // Routing bit 3 reaches its output two clocks after the write.
  route_ch3_a: assert property (@(posedge CLK) disable iff (RESET)
    WR && sel_route |=> ##1 ROUTE_CH3_ALT == $past(WDATA[3], 2))
    else $error("channel three route wrong");

  // The data address shows the latch for outputs and the pins for inputs.
  data_view_a: assert property (@(posedge CLK) disable iff (RESET)
    RD && sel_data |=> RDATA == (($past(dir_r) & $past(data_r)) | (~$past(dir_r) & $past(sync2_r))))
    else $error("data readback wrong");

  // The input address always shows the synchronised pins.
  input_read_a: assert property (@(posedge CLK) disable iff (RESET)
    RD && sel_input |=> RDATA == $past(sync2_r))
    else $error("input readback wrong");

  // Configuration writes land whatever the pin is doing.
  cfg_write_a: assert property (@(posedge CLK) disable iff (RESET)
    WR && sel_pe |=> pull_en_r == $past(WDATA))
    else $error("pull enable write lost");

  // A kept buffer stays on with the motor controller off.
  keep_buf_a: assert property (@(posedge CLK) disable iff (RESET)
    !MOTOR_EN && KEEP_BUF[0] |=> IBUF_EN[0])
    else $error("kept input buffer disabled");

  // Pins reach the read path after exactly two clocks.
  sync_lag_a: assert property (@(posedge CLK) disable iff (RESET)
    ##2 sync2_r == $past(PIN_IN, 2))
    else $error("input lag not two clocks");

  // The edge select is a copy of the polarity bits.
  edge_sel_a: assert property (@(posedge CLK) disable iff (RESET)
    ##1 EDGE_RISE == $past(pull_pol_r))
    else $error("edge select wrong");

  // A peripheral that owns a pin sets its direction.
  pin_oe_a: assert property (@(posedge CLK) disable iff (RESET)
    1'b1 |=> PIN_OE == (($past(PERIPH_EN) & $past(PERIPH_OE)) | (~$past(PERIPH_EN) & $past(dir_r))))
    else $error("pin direction wrong");

  // Main scenarios that the bench is expected to reach.
  pull_up_c: cover property (@(posedge CLK) |PULL_UP_EN);
  pull_dn_c: cover property (@(posedge CLK) |PULL_DN_EN);
  stop_c: cover property (@(posedge CLK) STOP_MODE && |slew_r);
  route_c: cover property (@(posedge CLK) ROUTE_CH2_ALT && ROUTE_CH3_ALT);
  keep_c: cover property (@(posedge CLK) !MOTOR_EN && |(KEEP_BUF & SLEW_EN));
endmodule // pvc_top
`default_nettype wire

// ---- pvc_pin_model.sv ----
// Purpose: Board circuitry seen by the port V pins.
// Assumes: A pull only acts on a pin that nothing drives.
// Notes: An undriven, unpulled pin shows the board level.
`timescale 1ns/1ns
`default_nettype none
module pvc_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_dn_en,
  input wire logic [7:0] board,
  output logic [7:0] pin_in
);
  // The port drive wins, then a pull device, then the board.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pull_up_en | (~pull_dn_en & board)));
endmodule // pvc_pin_model
`default_nettype wire

// ---- tb_pvc_top.sv ----
// Purpose: Self-checking bench for the port V configuration block.
// Assumes: Strobes change just after a rising edge.
// Notes: Outputs are checked three or more edges after the write is taken.
`timescale 1ns/1ns
`default_nettype none
module tb_pvc_top;
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, MOTOR_EN = 0, STOP_MODE = 0;
  logic [3:0] ADDR = 0;
  logic [7:0] WDATA = 0, PERIPH_OE = 0, PERIPH_OUT = 0, PERIPH_EN = 0, KEEP_BUF = 0;
  logic [7:0] board = 8'h00, v, RDATA, PIN_IN, PIN_OUT, PIN_OE, PULL_UP_EN, PULL_DN_EN;
  logic [7:0] SLEW_EN, IBUF_EN, EDGE_RISE;
  logic ROUTE_CH2_ALT, ROUTE_CH3_ALT;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Rows hold address, write value and expected readback.
  logic [19:0] rows [8] = '{20'h8A5A5, 20'h93C3C, 20'hA0F0F, 20'hBFF0C,
    20'h3FF00, 20'h7FF00, 20'hCFF00, 20'hFFF00};
  pvc_top pvc_top_inst (.CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .PIN_IN,
    .PERIPH_OE, .PERIPH_OUT, .PERIPH_EN, .KEEP_BUF, .MOTOR_EN, .STOP_MODE, .PIN_OUT,
    .PIN_OE, .PULL_UP_EN, .PULL_DN_EN, .SLEW_EN, .IBUF_EN, .EDGE_RISE, .ROUTE_CH2_ALT,
    .ROUTE_CH3_ALT);
  pvc_pin_model pvc_pin_model_inst (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pull_up_en(PULL_UP_EN), .pull_dn_en(PULL_DN_EN), .board(board), .pin_in(PIN_IN));
  always #4 CLK = ~CLK;
  // The ceiling is well above the fewer than two hundred cycles the tests need.
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge CLK);
    WR <= 0;
  endtask
  // Read data stand only in the cycle after the strobe is taken.
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge CLK);
    RD <= 0;
    @(negedge CLK);
    d = RDATA;
  endtask
  task settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 0;
    #1;
    chk("ibuf", 8'hFF, IBUF_EN);
    chk("pulls", 8'h00, PULL_UP_EN | PULL_DN_EN);
    rd(4'h8, v);
    chk("pull_en", 8'h00, v);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], v);
      chk("readback", rows[i][7:0], v);
    end
    $display("test registers done");
    wr(4'h8, 8'hFF);
    wr(4'h9, 8'h0F);
    wr(4'hA, 8'h00);
    settle();
    chk("pull_dn", 8'h0F, PULL_DN_EN);
    chk("pull_up", 8'hF0, PULL_UP_EN);
    chk("edge", 8'h0F, EDGE_RISE);
    chk("route", 8'h03, {6'h0, ROUTE_CH3_ALT, ROUTE_CH2_ALT});
    rd(4'h1, v);
    chk("input", 8'hF0, v);
    wr(4'hB, 8'h04);
    settle();
    chk("route", 8'h01, {6'h0, ROUTE_CH3_ALT, ROUTE_CH2_ALT});
    $display("test pulls done");
    wr(4'h0, 8'h5A);
    wr(4'h2, 8'hFF);
    settle();
    chk("oe", 8'hFF, PIN_OE);
    chk("pulls", 8'h00, PULL_UP_EN | PULL_DN_EN);
    rd(4'h0, v);
    chk("data", 8'h5A, v);
    rd(4'h1, v);
    chk("input", 8'h5A, v);
    wr(4'h2, 8'h00);
    settle();
    rd(4'h0, v);
    chk("data", 8'hF0, v);
    @(posedge CLK);
    PERIPH_EN <= 8'h01;
    PERIPH_OE <= 8'h01;
    PERIPH_OUT <= 8'h01;
    settle();
    chk("periph", 8'h01, PIN_OE & PIN_OUT);
    $display("test direction done");
    wr(4'hA, 8'hFF);
    repeat (pvc_pkg::SLEW_SETTLE_CYC) @(posedge CLK);
    #1;
    chk("slew", 8'hFF, SLEW_EN);
    chk("ibuf", 8'h00, IBUF_EN);
    @(posedge CLK);
    KEEP_BUF <= 8'h81;
    settle();
    chk("keep", 8'h81, IBUF_EN);
    @(posedge CLK);
    MOTOR_EN <= 1;
    settle();
    chk("motor", 8'h00, IBUF_EN);
    @(posedge CLK);
    MOTOR_EN <= 0;
    STOP_MODE <= 1;
    settle();
    chk("stop", 8'h00, SLEW_EN);
    @(posedge CLK);
    STOP_MODE <= 0;
    repeat (pvc_pkg::SLEW_SETTLE_CYC) @(posedge CLK);
    #1;
    chk("wake", 8'hFF, SLEW_EN);
    $display("test slew done");
    print_verdict();
  end
endmodule // tb_pvc_top
`default_nettype wire
